// file: rtl/ssp_pkg.sv
// Shared constants and types of the synchronous serial port slave.
package ssp_pkg;

	// ----------------------------------------------------------------
	// Mode selection codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_SPI_SS = 4'h4;
	localparam logic [3:0] MODE_SPI_NOSS = 4'h5;
	localparam logic [3:0] MODE_I2C_S7 = 4'h6;
	localparam logic [3:0] MODE_I2C_S10 = 4'h7;
	localparam logic [3:0] MODE_I2C_MST = 4'h8;
	localparam logic [3:0] MODE_I2C_FW = 4'hB;
	localparam logic [3:0] MODE_I2C_S7I = 4'hE;
	localparam logic [3:0] MODE_I2C_S10I = 4'hF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SPIKE_NS = 50;
	localparam int FILT_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Field values and counts
	// ----------------------------------------------------------------
	localparam logic [2:0] SPI_LAST_BIT = 3'h7;
	localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
	localparam logic [3:0] I2C_ACK_BIT = 4'h9;
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
	localparam logic [7:0] IDLE_TX_BYTE = 8'h00;
	localparam logic [3:0] FILT_CNT_W1 = 4'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic [3:0] mode;
		logic cke;
		logic ckp;
	} ssp_ctrl_type;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic data_not_addr;
		logic read_xfer;
		logic update_addr;
		logic buf_full;
	} ssp_status_type;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR2,
		I2C_DATA,
		I2C_IGNORE
	} ssp_i2c_state_type;

	typedef struct packed {
		logic sck_s1;
		logic sck_s2;
		logic sck_d;
		logic ss_s1;
		logic ss_s2;
		logic sdi_s1;
		logic sdi_s2;
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		logic scl_f;
		logic sda_f;
		logic [3:0] scl_cnt;
		logic [3:0] sda_cnt;
		logic [2:0] bit_cnt;
		logic [3:0] i2c_cnt;
		ssp_i2c_state_type i2c_st;
		logic [7:0] rx_shift;
		logic [7:0] tx_shift;
		logic tx_real;
		logic [7:0] buffer;
		ssp_status_type status;
		logic byte_done;
		logic overflow;
		logic wake;
		logic sdo_out;
		logic sdo_oe;
		logic sda_oe;
		logic scl_oe;
		logic [7:0] brg_cnt;
	} ssp_state_type;

endpackage

// file: rtl/ssp_buf.sv
// Small valid/ready buffer that holds transmit bytes ahead of the shifter.
`timescale 1ns/1ps
module ssp_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} ssp_buf_state_type;

	ssp_buf_state_type b_reg;
	ssp_buf_state_type b_next;
	logic push;
	logic pop;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_bad_cfg
		$error("ssp_buf needs a power-of-two depth of two or more");
	end

	assign in_ready = (b_reg.count != CW'(DEPTH));
	assign out_valid = (b_reg.count != '0);
	assign out_data = b_reg.mem[b_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		b_next = b_reg;
		if (push)
		begin
			b_next.mem[b_reg.wr_ptr] = in_data;
			b_next.wr_ptr = b_reg.wr_ptr + PW'(1);
		end
		if (pop)
		begin
			b_next.rd_ptr = b_reg.rd_ptr + PW'(1);
		end
		if (push && !pop)
		begin
			b_next.count = b_reg.count + CW'(1);
		end
		else if (pop && !push)
		begin
			b_next.count = b_reg.count - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			b_reg <= '0;
		else
			b_reg <= b_next;
	end
endmodule

// file: rtl/ssp_port.sv
// Synchronous serial port: SPI slave and I2C slave receive with double buffering.
`timescale 1ns/1ps
// Functional notes
// - Slave shifts on SCK, flags byte done.
// - Keeps running in sleep; byte raises wake.
// - Mode 0100 drives SDO only when select low.
// - Select high releases SDO three clocks later, even mid-byte.
// - Select high or disable zeroes bit counter.
// - SDO configured input never transmits.
// - Nothing works unless port enable set.
// - I2C inputs glitch filtered at any speed.
// - Mode bits choose the I2C role.
// - Master clock is fosc over 4(baud+1).
// - Status shows start, stop, D/A, UA, R/W.
// - Full byte moves to buffer, flag set.
// - Byte with buffer unread sets overflow, lost.
// - Buffer accessible, shift register hidden.
// - I2C slave, 7/10-bit; general call in 7-bit modes only.
// - No ACK when buffer full or overflow.
module ssp_port #(
	parameter int FILT_LEN = ssp_pkg::FILT_CYCLES,
	parameter int TX_DEPTH = 2
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire ssp_pkg::ssp_ctrl_type CTRL,
	input wire logic [9:0] ADDRESS_BAUD,
	input wire logic GCALL_EN,
	input wire logic SDO_DIR_IN,
	input wire logic SCK_IN,
	input wire logic SDI_IN,
	input wire logic SS_N_IN,
	output logic SDO_OUT,
	output logic SDO_OE,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	output logic TX_READY,
	output logic [7:0] RX_DATA,
	input wire logic BUF_RD,
	input wire logic FLAG_CLR,
	input wire logic OV_CLR,
	output logic BYTE_DONE,
	output logic OVERFLOW,
	output ssp_pkg::ssp_status_type STATUS,
	output logic WAKE_REQ
);
	import ssp_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (FILT_LEN < 1 || FILT_LEN > 15)
	begin : g_bad_filt
		$error("ssp_port glitch filter length must be 1 to 15");
	end

	ssp_state_type s_reg;
	ssp_state_type s_next;
	logic tx_pop;
	logic tx_valid;
	logic [7:0] tx_head;

	ssp_buf #(
		.WIDTH(8),
		.DEPTH(TX_DEPTH)
	) u_tx_buf (
		.clk(MCLK),
		.rst_n(RST_N),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(TX_DATA),
		.out_valid(tx_valid),
		.out_ready(tx_pop),
		.out_data(tx_head)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A line is accepted only after it has held a new level for the whole filter time.
	function automatic logic [4:0] filt_step(input logic raw, input logic cur,
		input logic [3:0] cnt);
		logic [4:0] r;
		r = {cur, 4'h0};
		if (raw != cur)
		begin
			if (cnt + FILT_CNT_W1 >= 4'(FILT_LEN))
				r = {raw, 4'h0};
			else
				r = {cur, cnt + FILT_CNT_W1};
		end
		return r;
	endfunction

	function automatic logic is_i2c_slave(input logic [3:0] m);
		return m == MODE_I2C_S7 || m == MODE_I2C_S10 || m == MODE_I2C_S7I ||
			m == MODE_I2C_S10I;
	endfunction

	function automatic logic is_ten_bit(input logic [3:0] m);
		return m == MODE_I2C_S10 || m == MODE_I2C_S10I;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic spi_mode;
		logic spi_rst;
		logic act;
		logic act_d;
		logic samp;
		logic shft;
		logic rx_done;
		logic [7:0] rx_byte;
		logic [4:0] fs;
		logic scl_rise;
		logic scl_fall;
		logic i2c_start;
		logic i2c_stop;
		logic match;
		logic [7:0] reload;
		spi_mode = 1'b0;
		spi_rst = 1'b0;
		act = 1'b0;
		act_d = 1'b0;
		samp = 1'b0;
		shft = 1'b0;
		rx_done = 1'b0;
		rx_byte = 8'h00;
		fs = 5'h00;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		i2c_start = 1'b0;
		i2c_stop = 1'b0;
		match = 1'b0;
		reload = 8'h00;
		tx_pop = 1'b0;
		s_next = s_reg;
		s_next.wake = 1'b0;

		// Two-stage synchronisers on every pin input.
		s_next.sck_s1 = SCK_IN;
		s_next.sck_s2 = s_reg.sck_s1;
		s_next.sck_d = s_reg.sck_s2;
		s_next.ss_s1 = SS_N_IN;
		s_next.ss_s2 = s_reg.ss_s1;
		s_next.sdi_s1 = SDI_IN;
		s_next.sdi_s2 = s_reg.sdi_s1;
		s_next.scl_s1 = SCL_IN;
		s_next.scl_s2 = s_reg.scl_s1;
		s_next.sda_s1 = SDA_IN;
		s_next.sda_s2 = s_reg.sda_s1;

		// The filter has no speed setting, so it is always in the path.
		fs = filt_step(s_reg.scl_s2, s_reg.scl_f, s_reg.scl_cnt);
		s_next.scl_f = fs[4];
		s_next.scl_cnt = fs[3:0];
		fs = filt_step(s_reg.sda_s2, s_reg.sda_f, s_reg.sda_cnt);
		s_next.sda_f = fs[4];
		s_next.sda_cnt = fs[3:0];

		// ------------------------------------------------------------
		// SPI slave
		// ------------------------------------------------------------
		spi_mode = CTRL.enable && (CTRL.mode == MODE_SPI_SS || CTRL.mode == MODE_SPI_NOSS);
		spi_rst = !CTRL.enable || (CTRL.mode == MODE_SPI_SS && s_reg.ss_s2);
		act = s_reg.sck_s2 ^ CTRL.ckp;
		act_d = s_reg.sck_d ^ CTRL.ckp;
		samp = CTRL.cke ? (act && !act_d) : (!act && act_d);
		shft = CTRL.cke ? (!act && act_d) : (act && !act_d);
		if (!spi_mode || spi_rst)
		begin
			s_next.bit_cnt = 3'h0;
			if (s_reg.bit_cnt != 3'h0)
			begin
				s_next.tx_real = 1'b0;
				s_next.tx_shift = IDLE_TX_BYTE;
			end
		end
		else
		begin
			if (samp)
			begin
				s_next.rx_shift = {s_reg.rx_shift[6:0], s_reg.sdi_s2};
				s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
				if (s_reg.bit_cnt == SPI_LAST_BIT)
				begin
					rx_done = 1'b1;
					rx_byte = {s_reg.rx_shift[6:0], s_reg.sdi_s2};
					s_next.tx_real = 1'b0;
					s_next.tx_shift = IDLE_TX_BYTE;
				end
			end
			else if (shft && s_reg.bit_cnt != 3'h0)
			begin
				s_next.tx_shift = {s_reg.tx_shift[6:0], 1'b0};
			end
		end
		// A queued word replaces the idle byte only between bytes.
		if (spi_mode && s_reg.bit_cnt == 3'h0 && !samp && !shft && !s_reg.tx_real && tx_valid)
		begin
			tx_pop = 1'b1;
			s_next.tx_shift = tx_head;
			s_next.tx_real = 1'b1;
		end
		s_next.sdo_out = s_next.tx_shift[7];
		s_next.sdo_oe = spi_mode && !SDO_DIR_IN &&
			!(CTRL.mode == MODE_SPI_SS && s_reg.ss_s2);

		// ------------------------------------------------------------
		// I2C slave
		// ------------------------------------------------------------
		scl_rise = s_next.scl_f && !s_reg.scl_f;
		scl_fall = !s_next.scl_f && s_reg.scl_f;
		i2c_start = s_reg.scl_f && s_next.scl_f && s_reg.sda_f && !s_next.sda_f;
		i2c_stop = s_reg.scl_f && s_next.scl_f && !s_reg.sda_f && s_next.sda_f;
		if (!CTRL.enable)
		begin
			s_next.i2c_st = I2C_IDLE;
			s_next.i2c_cnt = 4'h0;
			s_next.sda_oe = 1'b0;
			s_next.status.start_seen = 1'b0;
			s_next.status.stop_seen = 1'b0;
		end
		else if (i2c_start || i2c_stop)
		begin
			s_next.status.start_seen = i2c_start;
			s_next.status.stop_seen = i2c_stop;
			s_next.i2c_st = (i2c_start && is_i2c_slave(CTRL.mode)) ? I2C_ADDR : I2C_IDLE;
			s_next.i2c_cnt = 4'h0;
			s_next.sda_oe = 1'b0;
			if (CTRL.mode == MODE_I2C_S7I || CTRL.mode == MODE_I2C_S10I ||
				CTRL.mode == MODE_I2C_FW)
				s_next.byte_done = 1'b1;
		end
		else if (is_i2c_slave(CTRL.mode) && s_reg.i2c_st != I2C_IDLE &&
			s_reg.i2c_st != I2C_IGNORE)
		begin
			if (scl_rise)
			begin
				s_next.i2c_cnt = s_reg.i2c_cnt + 4'h1;
				if (s_reg.i2c_cnt < I2C_BYTE_BITS)
					s_next.rx_shift = {s_reg.rx_shift[6:0], s_reg.sda_f};
			end
			else if (scl_fall && s_reg.i2c_cnt == I2C_ACK_BIT)
			begin
				s_next.sda_oe = 1'b0;
				s_next.i2c_cnt = 4'h0;
			end
			else if (scl_fall && s_reg.i2c_cnt == I2C_BYTE_BITS)
			begin
				case (s_reg.i2c_st)
					I2C_ADDR:
					begin
						if (is_ten_bit(CTRL.mode))
						begin
							match = s_reg.rx_shift[7:3] == TEN_BIT_HDR &&
								s_reg.rx_shift[2:1] == ADDRESS_BAUD[9:8] && !s_reg.rx_shift[0];
							s_next.i2c_st = match ? I2C_ADDR2 : I2C_IGNORE;
							s_next.status.update_addr = match;
						end
						else
						begin
							match = !s_reg.rx_shift[0] && (s_reg.rx_shift[7:1] == ADDRESS_BAUD[7:1] ||
								(GCALL_EN && s_reg.rx_shift == GEN_CALL_ADDR));
							s_next.i2c_st = match ? I2C_DATA : I2C_IGNORE;
						end
						if (match)
						begin
							s_next.status.read_xfer = s_reg.rx_shift[0];
							s_next.status.data_not_addr = 1'b0;
						end
					end
					I2C_ADDR2:
					begin
						match = s_reg.rx_shift == ADDRESS_BAUD[7:0];
						s_next.i2c_st = match ? I2C_DATA : I2C_IGNORE;
						s_next.status.update_addr = 1'b0;
					end
					I2C_DATA:
					begin
						match = 1'b1;
						s_next.status.data_not_addr = 1'b1;
					end
					default:
					begin
						match = 1'b0;
					end
				endcase
				if (match)
				begin
					rx_done = 1'b1;
					rx_byte = s_reg.rx_shift;
					s_next.sda_oe = !s_reg.status.buf_full && !s_reg.overflow;
				end
			end
		end
		else if (!is_i2c_slave(CTRL.mode))
		begin
			s_next.i2c_st = I2C_IDLE;
			s_next.sda_oe = 1'b0;
		end

		// ------------------------------------------------------------
		// Master clock generator
		// ------------------------------------------------------------
		reload = {ADDRESS_BAUD[6:0], 1'b1};
		if (CTRL.enable && CTRL.mode == MODE_I2C_MST)
		begin
			if (s_reg.brg_cnt != 8'h00)
				s_next.brg_cnt = s_reg.brg_cnt - 8'h01;
			else if (s_reg.scl_oe || s_reg.scl_f)
			begin
				// Holding the reload while SCL is still low lets a slave stretch the clock.
				s_next.scl_oe = !s_reg.scl_oe;
				s_next.brg_cnt = reload;
			end
		end
		else
		begin
			s_next.scl_oe = 1'b0;
			s_next.brg_cnt = 8'h00;
		end

		// ------------------------------------------------------------
		// Receive buffer and flags
		// ------------------------------------------------------------
		if (BUF_RD)
			s_next.status.buf_full = 1'b0;
		if (FLAG_CLR)
			s_next.byte_done = 1'b0;
		if (OV_CLR)
			s_next.overflow = 1'b0;
		// Byte set comes after clear, so a byte received in the clearing cycle survives.
		if (rx_done)
		begin
			s_next.byte_done = 1'b1;
			s_next.wake = 1'b1;
			if (!s_reg.status.buf_full)
			begin
				s_next.buffer = rx_byte;
				s_next.status.buf_full = 1'b1;
			end
			else
			begin
				s_next.overflow = 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign SDO_OUT = s_reg.sdo_out;
	assign SDO_OE = s_reg.sdo_oe;
	assign SCL_OUT = 1'b0;
	assign SCL_OE = s_reg.scl_oe;
	assign SDA_OUT = 1'b0;
	assign SDA_OE = s_reg.sda_oe;
	assign RX_DATA = s_reg.buffer;
	assign BYTE_DONE = s_reg.byte_done;
	assign OVERFLOW = s_reg.overflow;
	assign STATUS = s_reg.status;
	assign WAKE_REQ = s_reg.wake;
endmodule

// file: testbench/ssp_checker.sv
// Concurrent checks on the serial port slave boundary.
`timescale 1ns/1ps
module ssp_checker (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire ssp_pkg::ssp_ctrl_type CTRL,
	input wire logic SDO_DIR_IN,
	input wire logic SS_N_IN,
	input wire logic SDO_OE,
	input wire logic SCL_OE,
	input wire logic SDA_OE,
	input wire logic [7:0] RX_DATA,
	input wire logic BUF_RD,
	input wire logic FLAG_CLR,
	input wire logic BYTE_DONE,
	input wire logic OVERFLOW,
	input wire ssp_pkg::ssp_status_type STATUS,
	input wire logic WAKE_REQ
);
	import ssp_pkg::*;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	AST_SDO_INPUT_MODE: assert property (SDO_DIR_IN && $past(SDO_DIR_IN) |-> !SDO_OE)
		else $error("SDO driven while configured as input");
	AST_SS_RELEASE: assert property ((CTRL.mode == MODE_SPI_SS && SS_N_IN) [*5] |-> !SDO_OE)
		else $error("SDO still driven after select went high");
	AST_SS_DRIVE: assert property ((CTRL.enable && CTRL.mode == MODE_SPI_SS && !SDO_DIR_IN
		&& !SS_N_IN) [*6] |-> SDO_OE)
		else $error("SDO not driven while selected");
	AST_DISABLED_QUIET: assert property ((!CTRL.enable) [*4] |-> !SDO_OE && !SDA_OE
		&& !SCL_OE && !WAKE_REQ)
		else $error("Port active while disabled");
	AST_WAKE_ONE_CYCLE: assert property (WAKE_REQ |=> !WAKE_REQ)
		else $error("Wake request longer than one cycle");
	AST_WAKE_WITH_FLAG: assert property (WAKE_REQ |-> BYTE_DONE && (STATUS.buf_full || OVERFLOW))
		else $error("Wake request without a received byte");
	AST_OVERFLOW_KEEPS: assert property ($rose(OVERFLOW) |-> $past(STATUS.buf_full)
		&& $stable(RX_DATA))
		else $error("Overflow without full buffer or buffer overwritten");
	AST_RX_HELD: assert property (STATUS.buf_full && $past(STATUS.buf_full) && !$past(BUF_RD)
		|-> $stable(RX_DATA))
		else $error("Unread buffer overwritten");
	AST_FLAG_STICKY: assert property (BYTE_DONE && !FLAG_CLR |=> BYTE_DONE)
		else $error("Byte flag dropped without clear");
	cover property ($rose(OVERFLOW));
	cover property ($fell(SDO_OE));
	cover property (WAKE_REQ);
	cover property ($rose(SDA_OE));
	cover property ($rose(SCL_OE));
endmodule
bind ssp_port ssp_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .CTRL(CTRL),
	.SDO_DIR_IN(SDO_DIR_IN), .SS_N_IN(SS_N_IN), .SDO_OE(SDO_OE), .SCL_OE(SCL_OE),
	.SDA_OE(SDA_OE), .RX_DATA(RX_DATA), .BUF_RD(BUF_RD), .FLAG_CLR(FLAG_CLR),
	.BYTE_DONE(BYTE_DONE), .OVERFLOW(OVERFLOW), .STATUS(STATUS), .WAKE_REQ(WAKE_REQ));

// file: testbench/ssp_spi_master.sv
// Behavioural SPI and I2C masters that drive the slave's serial pins.
`timescale 1ns/1ps
module ssp_spi_master (
	input wire logic mclk,
	input wire logic sdo,
	input wire logic sdo_oe,
	output logic sck,
	output logic sdi,
	output logic ss_n
);
	logic last_rx = 1'b0;
	// Clock idles low outside frames; each phase is five system clocks, above the minimum.
	initial
	begin
		sck = 1'b0;
		sdi = 1'b1;
		ss_n = 1'b1;
	end
	task automatic select(input logic on);
		@(posedge mclk);
		#1;
		ss_n = !on;
		sdi = !sdi;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nbits; i++)
		begin
			@(posedge mclk);
			#1;
			sdi = tx[7 - i];
			repeat (4) @(posedge mclk);
			// A floating pin is read as the inverse of its last level.
			last_rx = sdo_oe ? sdo : !last_rx;
			rx = {rx[6:0], last_rx};
			#1;
			sck = 1'b1;
			repeat (5) @(posedge mclk);
			#1;
			sck = 1'b0;
		end
		@(posedge mclk);
		#1;
		sdi = !sdi;
	endtask
endmodule

// ----------------------------------------
// I2C bus master
// ----------------------------------------
module ssp_i2c_master (
	input wire logic mclk,
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	// Both lines have pull-ups, so a line is low while either side pulls it.
	assign scl = scl_m && !scl_oe;
	assign sda = sda_m && !sda_oe;
	task automatic half();
		repeat (6) @(posedge mclk);
		#1;
	endtask
	// With the clock low this also makes a repeated start.
	task automatic start();
		half();
		sda_m = 1'b1;
		half();
		scl_m = 1'b1;
		half();
		sda_m = 1'b0;
		half();
		scl_m = 1'b0;
	endtask
	task automatic stop();
		half();
		sda_m = 1'b0;
		half();
		scl_m = 1'b1;
		half();
		sda_m = 1'b1;
		half();
	endtask
	// Eight bits MSB first, then a released ninth bit on which the slave may acknowledge.
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic [8:0] bits;
		bits = {d, 1'b1};
		ack = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			half();
			sda_m = bits[8 - i];
			half();
			scl_m = 1'b1;
			half();
			ack = !sda;
			scl_m = 1'b0;
		end
	endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the serial port slave in SPI and I2C modes.
`timescale 1ns/1ps
module testbench;
	import ssp_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	ssp_ctrl_type ctrl = '{enable: 1'b1, mode: MODE_SPI_SS, cke: 1'b1, ckp: 1'b0};
	logic sdo_dir_in = 1'b0;
	logic tx_valid = 1'b0;
	logic buf_rd = 1'b0;
	logic flag_clr = 1'b0;
	logic ov_clr = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [9:0] addr_baud = 10'h000;
	logic gcall_en = 1'b0;
	logic scl_line, sda_line, scl_oe, sda_oe, scl_out, sda_out;
	logic sck, sdi, ss_n, sdo_out, sdo_oe, tx_ready, byte_done, overflow, wake_req;
	logic [7:0] rx_data;
	ssp_status_type status;
	int err_total = 0;
	int n_compared = 0;
	int wake_cnt = 0;
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (wake_req === 1'b1) wake_cnt++;
	// ----------------------------------------
	// Design and far side
	// ----------------------------------------
	ssp_port #(.FILT_LEN(1), .TX_DEPTH(2)) dut (.MCLK(mclk), .RST_N(rst_n), .CTRL(ctrl),
		.ADDRESS_BAUD(addr_baud), .GCALL_EN(gcall_en), .SDO_DIR_IN(sdo_dir_in), .SCK_IN(sck),
		.SDI_IN(sdi), .SS_N_IN(ss_n), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe), .SCL_IN(scl_line),
		.SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_line), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .BUF_RD(buf_rd),
		.FLAG_CLR(flag_clr), .OV_CLR(ov_clr), .BYTE_DONE(byte_done), .OVERFLOW(overflow),
		.STATUS(status), .WAKE_REQ(wake_req));
	ssp_spi_master u_master (.mclk(mclk), .sdo(sdo_out), .sdo_oe(sdo_oe), .sck(sck),
		.sdi(sdi), .ss_n(ss_n));
	ssp_i2c_master u_i2c (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl_line),
		.sda(sda_line));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic clr();
		step(1);
		{buf_rd, flag_clr, ov_clr} = 3'h7;
		step(1);
		{buf_rd, flag_clr, ov_clr} = 3'h0;
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		u_master.xfer(tx, 8, rx);
		step(4);
	endtask
	task automatic push(input logic [7:0] d);
		int n;
		step(1);
		tx_data = d;
		tx_valid = 1'b1;
		n = 0;
		while (tx_ready !== 1'b1 && n < 50)
		begin
			step(1);
			n++;
		end
		step(1);
		tx_valid = 1'b0;
	endtask
	task automatic wait_scl(input logic v, inout int n);
		int k;
		k = 0;
		while (scl_oe !== v && k < 100)
		begin
			step(1);
			n++;
			k++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_rx_overflow();
		logic [7:0] rx;
		int w;
		clr();
		w = wake_cnt;
		u_master.select(1'b1);
		byte_io(8'hA5, rx);
		check("byte_done", {7'h00, byte_done}, 8'h01);
		check("rx_data", rx_data, 8'hA5);
		check("buf_full", {7'h00, status.buf_full}, 8'h01);
		check("wake", 8'(wake_cnt - w), 8'h01);
		byte_io(8'h3C, rx);
		check("overflow", {7'h00, overflow}, 8'h01);
		check("rx_kept", rx_data, 8'hA5);
		clr();
		check("flags_cleared", {6'h00, byte_done, overflow}, 8'h00);
		byte_io(8'h5A, rx);
		check("rx_next", rx_data, 8'h5A);
		u_master.select(1'b0);
		$display("test rx_overflow done");
	endtask
	task automatic t_ss_abort();
		logic [7:0] rx;
		clr();
		u_master.select(1'b1);
		check("sdo_driven", {7'h00, sdo_oe}, 8'h01);
		u_master.xfer(8'hF0, 3, rx);
		u_master.select(1'b0);
		step(5);
		check("sdo_released", {7'h00, sdo_oe}, 8'h00);
		check("no_partial_byte", {7'h00, byte_done}, 8'h00);
		u_master.select(1'b1);
		byte_io(8'h69, rx);
		check("rx_after_abort", rx_data, 8'h69);
		u_master.select(1'b0);
		$display("test ss_abort done");
	endtask
	task automatic t_sdo_input();
		logic [7:0] rx;
		clr();
		sdo_dir_in = 1'b1;
		u_master.select(1'b1);
		check("sdo_input_quiet", {7'h00, sdo_oe}, 8'h00);
		byte_io(8'h96, rx);
		check("rx_receive_only", rx_data, 8'h96);
		u_master.select(1'b0);
		sdo_dir_in = 1'b0;
		$display("test sdo_input done");
	endtask
	task automatic t_tx_buffer();
		logic [7:0] rx;
		clr();
		// The shifter takes the first word at once, so three pushes fill the buffer.
		push(8'hA1);
		push(8'hB2);
		push(8'hC3);
		check("tx_full", {7'h00, tx_ready}, 8'h00);
		// A push while full must be refused and never reach the wire.
		tx_data = 8'hD4;
		tx_valid = 1'b1;
		step(3);
		check("tx_refused", {7'h00, tx_ready}, 8'h00);
		tx_valid = 1'b0;
		u_master.select(1'b1);
		byte_io(8'h11, rx);
		check("tx_first", rx, 8'hA1);
		byte_io(8'h22, rx);
		check("tx_second", rx, 8'hB2);
		byte_io(8'h33, rx);
		check("tx_third", rx, 8'hC3);
		byte_io(8'h44, rx);
		check("tx_drained", rx, IDLE_TX_BYTE);
		check("tx_empty", {7'h00, tx_ready}, 8'h01);
		u_master.select(1'b0);
		$display("test tx_buffer done");
	endtask
	task automatic t_disabled();
		logic [7:0] rx;
		clr();
		ctrl.enable = 1'b0;
		u_master.select(1'b1);
		byte_io(8'hFF, rx);
		check("off_no_byte", {7'h00, byte_done}, 8'h00);
		check("off_no_drive", {7'h00, sdo_oe}, 8'h00);
		u_master.select(1'b0);
		ctrl.enable = 1'b1;
		$display("test disabled done");
	endtask
	task automatic t_i2c_slave();
		logic ack;
		clr();
		ctrl.mode = MODE_I2C_S7;
		addr_baud = 10'h0A4;
		u_i2c.start();
		check("start_seen", {7'h00, status.start_seen}, 8'h01);
		u_i2c.byte_out(8'hA4, ack);
		check("addr_ack", {7'h00, ack}, 8'h01);
		check("addr_buf", rx_data, 8'hA4);
		check("addr_flag", {7'h00, status.data_not_addr}, 8'h00);
		clr();
		u_i2c.byte_out(8'h5C, ack);
		check("data_ack", {7'h00, ack}, 8'h01);
		check("data_buf", rx_data, 8'h5C);
		check("data_flag", {7'h00, status.data_not_addr}, 8'h01);
		u_i2c.byte_out(8'h77, ack);
		check("full_nack", {7'h00, ack}, 8'h00);
		check("i2c_overflow", {6'h00, byte_done, overflow}, 8'h03);
		check("i2c_kept", rx_data, 8'h5C);
		u_i2c.stop();
		check("stop_seen", {6'h00, status.stop_seen, status.start_seen}, 8'h02);
		clr();
		gcall_en = 1'b1;
		u_i2c.start();
		u_i2c.byte_out(GEN_CALL_ADDR, ack);
		check("gcall_ack", {7'h00, ack}, 8'h01);
		clr();
		u_i2c.start();
		u_i2c.byte_out(8'h20, ack);
		check("other_nack", {7'h00, ack}, 8'h00);
		u_i2c.stop();
		$display("test i2c_slave done");
	endtask
	task automatic t_i2c_master();
		int n;
		n = 0;
		ctrl.mode = MODE_I2C_MST;
		addr_baud = 10'h004;
		wait_scl(1'b0, n);
		wait_scl(1'b1, n);
		n = 0;
		wait_scl(1'b0, n);
		wait_scl(1'b1, n);
		check("scl_period", 8'(n), 8'(4 * (addr_baud + 1)));
		check("od_levels", {5'h00, sda_oe, scl_out, sda_out}, 8'h00);
		$display("test i2c_master done");
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		step(2);
		t_rx_overflow();
		t_ss_abort();
		t_sdo_input();
		t_tx_buffer();
		t_disabled();
		t_i2c_slave();
		t_i2c_master();
		final_report();
	end
	// The tests need a few thousand cycles; this bound only cuts a hang.
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		final_report();
	end
endmodule
